// ==== bench/dgp_pad_model.sv ====
// Pad model of one 8-bit port: design drive, outside driver, pullup
// Assumes the bench drives the outside driver enable and level
`default_nettype none

module dgp_pad_model (
  // Design side
  input  wire logic [7:0] pin_o_i,
  input  wire logic [7:0] oe_n_i,
  input  wire logic [7:0] pull_i,
  // Outside drivers
  input  wire logic [7:0] ext_en_i,
  input  wire logic [7:0] ext_i,
  // Level seen by the design
  output logic      [7:0] pin_i_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Floating pins read high with pullup on, else the inverse of the latch, so a stale value never passes
  assign pin_i_o = (~oe_n_i & pin_o_i) | (oe_n_i & ext_en_i & ext_i)
                 | (oe_n_i & ~ext_en_i & (pull_i | ~pin_o_i));
endmodule // dgp_pad_model

`default_nettype wire

// ==== bench/dgp_port_asserts.sv ====
// Concurrent checks on the dual GPIO port top-level ports
// Assumes binding into every dgp_port instance, single clock domain
`include "dgp_regs.svh"
`default_nettype none

module dgp_port_asserts #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic                     clock_i,
  input wire logic                     srst_i,
  // Register bus
  input wire logic [15:0]              addr_i,
  input wire logic                     wr_i,
  input wire logic                     rd_i,
  input wire logic [WIDTH-1:0]         wdata_i,
  input wire logic [WIDTH-1:0]         rdata_o,
  // Converter and keyboard
  input wire logic                     adc_en_i,
  input wire logic [`DGP_ADC_CH_W-1:0] adc_ch_i,
  input wire logic [WIDTH-1:0]         keyboard_irq_enable_bits_i,
  input wire logic [WIDTH-1:0]         keyboard_inputs_o,
  // Pins
  input wire logic [WIDTH-1:0]         pin_a_o,
  input wire logic [WIDTH-1:0]         pin_a_oe_n_o,
  input wire logic [WIDTH-1:0]         pin_a_pullup_o,
  input wire logic [WIDTH-1:0]         analog_inputs_high_o,
  input wire logic [WIDTH-1:0]         pin_b_o,
  input wire logic [WIDTH-1:0]         pin_b_oe_n_o,
  input wire logic [WIDTH-1:0]         analog_inputs_low_o
);
  default clocking dgp_cb @(posedge clock_i); endclocking
  default disable iff (srst_i);

  // ==========================================================================
  // Assertions
  a_dir_reset: assert property (disable iff (1'b0) srst_i |=>
    (pin_a_oe_n_o & pin_b_oe_n_o) == 8'hff) else $error("directions not cleared by reset");
  a_pullup_off: assert property ((pin_a_pullup_o & ~pin_a_oe_n_o) == 8'h00)
    else $error("pullup on while pin driven");
  a_analog_a_take: assert property (adc_en_i && adc_ch_i[4:3] == 2'b01 |->
    analog_inputs_high_o == 8'h01 << adc_ch_i[2:0] && pin_a_oe_n_o[adc_ch_i[2:0]]
    && !pin_a_pullup_o[adc_ch_i[2:0]]) else $error("port A analog takeover wrong");
  a_analog_b_take: assert property (adc_en_i && adc_ch_i[4:3] == 2'b00 |->
    analog_inputs_low_o == 8'h01 << adc_ch_i[2:0] && pin_b_oe_n_o[adc_ch_i[2:0]])
    else $error("port B analog takeover wrong");
  a_latch_a_write: assert property (wr_i && addr_i == 16'h0000 |=>
    pin_a_o == $past(wdata_i)) else $error("port A latch not written");
  a_latch_b_write: assert property (wr_i && addr_i == 16'h0001 |=>
    pin_b_o == $past(wdata_i)) else $error("port B latch not written");
  a_read_a_latch: assert property (rd_i && !wr_i && addr_i == 16'h0000 |=>
    ((rdata_o ^ $past(pin_a_o)) & ~$past(pin_a_oe_n_o)) == 8'h00)
    else $error("port A output pin read wrong");
  a_dir_a_write: assert property (wr_i && addr_i == 16'h0004 |=>
    pin_a_oe_n_o == (~$past(wdata_i) | analog_inputs_high_o)) else $error("port A enable wrong");
  a_dir_b_write: assert property (wr_i && addr_i == 16'h0005 |=>
    pin_b_oe_n_o == (~$past(wdata_i) | analog_inputs_low_o)) else $error("port B enable wrong");
  a_keyboard_gate: assert property (
    (keyboard_inputs_o & ~$past(keyboard_irq_enable_bits_i)) == 8'h00)
    else $error("keyboard input passed while disabled");

  c_latch_write: cover property (wr_i && addr_i == 16'h0000);
  c_analog_a: cover property (adc_en_i && adc_ch_i[4:3] == 2'b01);
  c_read_b: cover property (rd_i && addr_i == 16'h0001);
endmodule // dgp_port_asserts

bind dgp_port dgp_port_asserts #(.WIDTH(WIDTH)) i_dgp_port_asserts (.*);

`default_nettype wire

// ==== bench/test_dual_gpio_port_with_pullups.sv ====
// Self-checking bench for the dual GPIO port
// Assumes dgp_port, dgp_pad_model and the checker are compiled before it
`default_nettype none

module test_dual_gpio_port_with_pullups;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [7:0] dir, latch, pue, en, ext, exp;} dgp_row_s;
  logic        clock_i = 0, srst_i = 1, wr_i = 0, rd_i = 0, adc_en_i = 0;
  logic [15:0] addr_i = 16'h0000;
  logic [4:0]  adc_ch_i = 5'h00;
  logic [7:0]  wdata_i = 8'h00, kbe = 8'h00, ext_a = 8'h00, en_a = 8'h00, ext_b = 8'h00;
  logic [7:0]  en_b = 8'h00, rdata_o, kbo, pa_i, pa_o, pa_oe, pa_pu, an_hi, pb_i, pb_o;
  logic [7:0]  pb_oe, an_lo;
  int          mismatches = 0, total_checks = 0;
  dgp_row_s    rows [4] = '{48'hffa5000000a5, 48'h00a5ff0000ff, 48'h0f3cff0000fc,
                            48'h0000_00ff9696};

  dgp_port i_dgp_port (.clock_i(clock_i), .srst_i(srst_i), .addr_i(addr_i), .wr_i(wr_i),
    .rd_i(rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .adc_en_i(adc_en_i),
    .adc_ch_i(adc_ch_i), .keyboard_irq_enable_bits_i(kbe), .keyboard_inputs_o(kbo),
    .pin_a_i(pa_i), .pin_a_o(pa_o), .pin_a_oe_n_o(pa_oe), .pin_a_pullup_o(pa_pu),
    .analog_inputs_high_o(an_hi), .pin_b_i(pb_i), .pin_b_o(pb_o), .pin_b_oe_n_o(pb_oe),
    .analog_inputs_low_o(an_lo));
  dgp_pad_model i_dgp_pad_model_a (.pin_o_i(pa_o), .oe_n_i(pa_oe), .pull_i(pa_pu),
    .ext_en_i(en_a), .ext_i(ext_a), .pin_i_o(pa_i));
  dgp_pad_model i_dgp_pad_model_b (.pin_o_i(pb_o), .oe_n_i(pb_oe), .pull_i(8'h00),
    .ext_en_i(en_b), .ext_i(ext_b), .pin_i_o(pb_i));

  initial begin
    forever #5 clock_i = ~clock_i;
  end

  // ==========================================================================
  // Tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clock_i);
    addr_i = a;
    wdata_i = d;
    wr_i = 1;
    @(negedge clock_i);
    wr_i = 0;
  endtask

  task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
    @(negedge clock_i);
    addr_i = a;
    rd_i = 1;
    @(negedge clock_i);
    rd_i = 0;
    chk(rdata_o, exp);
  endtask

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Whole run is well under 2000 cycles
  initial begin
    #50us;
    mismatches++;
    print_verdict();
  end

  // ==========================================================================
  // Sequence
  initial begin
    repeat (3) @(negedge clock_i);
    srst_i = 0;
    rdc(16'h0004, 8'h00);
    rdc(16'h0005, 8'h00);
    rdc(16'h000d, 8'h00);
    chk(pa_oe & pb_oe, 8'hff);
    foreach (rows[i]) begin
      wr(16'h0000, rows[i].latch);
      wr(16'h0004, rows[i].dir);
      wr(16'h000d, rows[i].pue);
      en_a = rows[i].en;
      ext_a = rows[i].ext;
      repeat (3) @(negedge clock_i);
      rdc(16'h0000, rows[i].exp);
    end
    // Latches must survive a mid-run reset
    wr(16'h0000, 8'h5a);
    wr(16'h0001, 8'hc3);
    srst_i = 1;
    @(negedge clock_i);
    srst_i = 0;
    wr(16'h0004, 8'hff);
    rdc(16'h0000, 8'h5a);
    wr(16'h0005, 8'hf0);
    en_b = 8'hff;
    ext_b = 8'h0f;
    repeat (3) @(negedge clock_i);
    rdc(16'h0001, 8'hcf);
    rdc(16'h0003, 8'h00);
    adc_en_i = 1;
    adc_ch_i = 5'h0a;
    @(negedge clock_i);
    chk(an_hi, 8'h04);
    chk(pa_oe, 8'h04);
    adc_ch_i = 5'h05;
    @(negedge clock_i);
    chk(an_lo, 8'h20);
    chk(pb_oe, 8'h2f);
    adc_en_i = 0;
    wr(16'h0004, 8'h00);
    ext_a = 8'h81;
    en_a = 8'hff;
    kbe = 8'h01;
    repeat (4) @(negedge clock_i);
    chk(kbo, 8'h01);
    wr(16'h000d, 8'hff);
    chk(pa_pu, 8'hff);
    wr(16'h0004, 8'h0f);
    chk(pa_pu, 8'hf0);
    chk(pa_o, 8'h5a);
    chk(pb_o, 8'hc3);
    print_verdict();
  end
endmodule // test_dual_gpio_port_with_pullups

`default_nettype wire

// ==== hdl/dgp_pin_cell.sv ====
// One port's pin drive logic: output enable, pullup, analog takeover
// Assumes enables and data come from the same clock domain
`default_nettype none

module dgp_pin_cell #(
  parameter int WIDTH = 8
) (
  // Control
  input  wire logic [WIDTH-1:0] latch_i,
  input  wire logic [WIDTH-1:0] dir_i,
  input  wire logic [WIDTH-1:0] pullup_en_i,
  input  wire logic [WIDTH-1:0] analog_sel_i,
  // Pin side, output enable active low
  output logic      [WIDTH-1:0] pin_o,
  output logic      [WIDTH-1:0] pin_oe_n_o,
  output logic      [WIDTH-1:0] pullup_on_o
);
  if (WIDTH < 1) begin : g_bad_width
    $error("dgp_pin_cell: WIDTH must be positive");
  end

  for (genvar i = 0; i < WIDTH; i++) begin : g_pin
    // Analog selection beats the direction bit
    assign pin_oe_n_o[i]  = ~(dir_i[i] & ~analog_sel_i[i]);
    assign pin_o[i]       = latch_i[i];
    // Pullup only on a digital input
    assign pullup_on_o[i] = pullup_en_i[i] & ~dir_i[i] & ~analog_sel_i[i];
  end
endmodule // dgp_pin_cell

`default_nettype wire

// ==== hdl/dgp_pkg.sv ====
// Types shared by the dual GPIO port
// Assumes nothing beyond the register header
`default_nettype none

package dgp_pkg;
  typedef enum logic [2:0] {
    DGP_SEL_NONE,
    DGP_SEL_A_LATCH,
    DGP_SEL_B_LATCH,
    DGP_SEL_A_DIR,
    DGP_SEL_B_DIR,
    DGP_SEL_A_PULLUP
  } dgp_sel_e;
endpackage : dgp_pkg

`default_nettype wire

// ==== hdl/dgp_port.sv ====
// Dual 8-bit GPIO port with data latches, direction bits and port A pullups
// Assumes a simple byte register bus on clock_i and asynchronous pins
//
// Functional notes
// - Port A has eight bidirectional pins shared with keyboard and converter
// - Port A data latches are software read/write and survive reset
// - Port A direction one enables the output buffer, zero makes input
// - Reset clears all port A direction bits
// - Port A read returns latch where direction is one
// - Port A read returns pin level where direction is zero
// - Latch writes always update, regardless of direction
// - Port A pullup enable connects pullup on input pins
// - Output direction disables the pin's pullup automatically
// - Keyboard enable bit makes the port A pin an interrupt input
// - Converter channel select on port A forces analog input
// - Port B has eight pins, converter shared, latches survive reset
// - Converter channel select on port B forces analog input
// - Port B direction one enables output buffer, zero makes input
// - Reset clears all port B direction bits
// - Port B read returns latch for outputs, pin level for inputs
`include "dgp_regs.svh"
`default_nettype none

module dgp_port
  import dgp_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic                     clock_i,
  input  wire logic                     srst_i,
  // Register bus
  input  wire logic [15:0]              addr_i,
  input  wire logic                     wr_i,
  input  wire logic                     rd_i,
  input  wire logic [WIDTH-1:0]         wdata_i,
  output logic      [WIDTH-1:0]         rdata_o,
  // Converter channel select
  input  wire logic                     adc_en_i,
  input  wire logic [`DGP_ADC_CH_W-1:0] adc_ch_i,
  // Keyboard unit
  input  wire logic [WIDTH-1:0]         keyboard_irq_enable_bits_i,
  output logic      [WIDTH-1:0]         keyboard_inputs_o,
  // Port A pins
  input  wire logic [WIDTH-1:0]         pin_a_i,
  output logic      [WIDTH-1:0]         pin_a_o,
  output logic      [WIDTH-1:0]         pin_a_oe_n_o,
  output logic      [WIDTH-1:0]         pin_a_pullup_o,
  output logic      [WIDTH-1:0]         analog_inputs_high_o,
  // Port B pins
  input  wire logic [WIDTH-1:0]         pin_b_i,
  output logic      [WIDTH-1:0]         pin_b_o,
  output logic      [WIDTH-1:0]         pin_b_oe_n_o,
  output logic      [WIDTH-1:0]         analog_inputs_low_o
);
  // ========================================================================
  // Elaboration checks
  // Read mux, channel decode and byte bus all assume byte-wide ports
  if (WIDTH != 8) begin : g_bad_width
    $error("dgp_port: WIDTH must be 8");
  end

  // Channel numbers must reach the top port A pin
  if (`DGP_ADC_CH_W < 4) begin : g_bad_chan_width
    $error("dgp_port: converter channel field too narrow");
  end

  // ========================================================================
  // Address decode
  function automatic dgp_sel_e decode(input logic [15:0] a);
    case (a)
      `DGP_OFS_A_LATCH:  decode = DGP_SEL_A_LATCH;
      `DGP_OFS_B_LATCH:  decode = DGP_SEL_B_LATCH;
      `DGP_OFS_A_DIR:    decode = DGP_SEL_A_DIR;
      `DGP_OFS_B_DIR:    decode = DGP_SEL_B_DIR;
      `DGP_OFS_A_PULLUP: decode = DGP_SEL_A_PULLUP;
      default:           decode = DGP_SEL_NONE;
    endcase
  endfunction

  // Channel decode into a one-hot pin mask for one port
  function automatic logic [7:0] chan_mask(input logic                     en,
                                           input logic [`DGP_ADC_CH_W-1:0] ch,
                                           input logic [`DGP_ADC_CH_W-1:0] base);
    logic [`DGP_ADC_CH_W-1:0] off;
    off       = ch - base;
    chan_mask = 8'h00;
    if (en && ch >= base && off < `DGP_ADC_CH_W'(8)) begin
      chan_mask[off[2:0]] = 1'b1;
    end
  endfunction

  // Read view of one pin: latch when direction is one, synchronised pad level otherwise
  function automatic logic pin_view(input logic dir,
                                    input logic latch,
                                    input logic pad);
    pin_view = dir ? latch : pad;
  endfunction

  dgp_sel_e sel;
  assign sel = decode(addr_i);

  // ========================================================================
  // Write strobes
  // A write to an unmapped address raises none of these and is dropped
  logic wr_a_latch;
  logic wr_b_latch;
  logic wr_a_dir;
  logic wr_b_dir;
  logic wr_a_pullup;

  assign wr_a_latch  = wr_i && (sel == DGP_SEL_A_LATCH);
  assign wr_b_latch  = wr_i && (sel == DGP_SEL_B_LATCH);
  assign wr_a_dir    = wr_i && (sel == DGP_SEL_A_DIR);
  assign wr_b_dir    = wr_i && (sel == DGP_SEL_B_DIR);
  assign wr_a_pullup = wr_i && (sel == DGP_SEL_A_PULLUP);

  // ========================================================================
  // Registers
  logic [WIDTH-1:0] port_a_latch_q;
  logic [WIDTH-1:0] port_b_latch_q;
  logic [WIDTH-1:0] port_a_direction_q;
  logic [WIDTH-1:0] port_b_direction_q;
  logic [WIDTH-1:0] port_a_pullup_enable_q;

  // Latches have no reset so contents persist through system reset
  always_ff @(posedge clock_i) begin
    if (wr_a_latch) begin
      port_a_latch_q <= wdata_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (wr_b_latch) begin
      port_b_latch_q <= wdata_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      port_a_direction_q <= `DGP_DIR_RESET;
    end else if (wr_a_dir) begin
      port_a_direction_q <= wdata_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      port_b_direction_q <= `DGP_DIR_RESET;
    end else if (wr_b_dir) begin
      port_b_direction_q <= wdata_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      port_a_pullup_enable_q <= `DGP_PULLUP_RESET;
    end else if (wr_a_pullup) begin
      port_a_pullup_enable_q <= wdata_i;
    end
  end

  // ========================================================================
  // Pin synchronisers
  logic [WIDTH-1:0] pin_a_sync;
  logic [WIDTH-1:0] pin_b_sync;

  dgp_sync #(.WIDTH(WIDTH)) u_sync_a (
    .clock_i (clock_i),
    .srst_i  (srst_i),
    .async_i (pin_a_i),
    .sync_o  (pin_a_sync)
  );

  dgp_sync #(.WIDTH(WIDTH)) u_sync_b (
    .clock_i (clock_i),
    .srst_i  (srst_i),
    .async_i (pin_b_i),
    .sync_o  (pin_b_sync)
  );

  // ========================================================================
  // Analog takeover
  logic [WIDTH-1:0] analog_a;
  logic [WIDTH-1:0] analog_b;

  assign analog_a = chan_mask(adc_en_i, adc_ch_i, `DGP_ADC_A_BASE);
  assign analog_b = chan_mask(adc_en_i, adc_ch_i, `DGP_ADC_B_BASE);
  assign analog_inputs_high_o = analog_a;
  assign analog_inputs_low_o  = analog_b;

  // ========================================================================
  // Pin drivers
  dgp_pin_cell #(.WIDTH(WIDTH)) u_cell_a (
    .latch_i      (port_a_latch_q),
    .dir_i        (port_a_direction_q),
    .pullup_en_i  (port_a_pullup_enable_q),
    .analog_sel_i (analog_a),
    .pin_o        (pin_a_o),
    .pin_oe_n_o   (pin_a_oe_n_o),
    .pullup_on_o  (pin_a_pullup_o)
  );

  // Port B has no pullups
  dgp_pin_cell #(.WIDTH(WIDTH)) u_cell_b (
    .latch_i      (port_b_latch_q),
    .dir_i        (port_b_direction_q),
    .pullup_en_i  ('0),
    .analog_sel_i (analog_b),
    .pin_o        (pin_b_o),
    .pin_oe_n_o   (pin_b_oe_n_o),
    .pullup_on_o  ()
  );

  // ========================================================================
  // Keyboard inputs
  // Analog pins are masked so a mid-rail voltage cannot raise an interrupt
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      keyboard_inputs_o <= '0;
    end else begin
      keyboard_inputs_o <= pin_a_sync & keyboard_irq_enable_bits_i & ~analog_a;
    end
  end

  // ========================================================================
  // Per-pin read view
  // Input pins read two clocks late; the synchroniser trades latency for safety
  logic [WIDTH-1:0] view_a;
  logic [WIDTH-1:0] view_b;

  for (genvar i = 0; i < WIDTH; i++) begin : g_view
    assign view_a[i] = pin_view(port_a_direction_q[i], port_a_latch_q[i], pin_a_sync[i]);
    assign view_b[i] = pin_view(port_b_direction_q[i], port_b_latch_q[i], pin_b_sync[i]);
  end

  // ========================================================================
  // Read data
  logic [WIDTH-1:0] rdata_d;

  always_comb begin
    case (sel)
      DGP_SEL_A_LATCH:  rdata_d = view_a;
      DGP_SEL_B_LATCH:  rdata_d = view_b;
      DGP_SEL_A_DIR:    rdata_d = port_a_direction_q;
      DGP_SEL_B_DIR:    rdata_d = port_b_direction_q;
      DGP_SEL_A_PULLUP: rdata_d = port_a_pullup_enable_q;
      default:          rdata_d = `DGP_UNMAPPED_READ;
    endcase
  end

  // Registered read data, valid one cycle after rd_i
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      rdata_o <= rdata_d;
    end
  end
endmodule // dgp_port

`default_nettype wire

// ==== hdl/dgp_regs.svh ====
// Register offsets, reset values and field layout for the dual GPIO port
// Assumes byte-wide register bus with 16-bit addresses
`ifndef DGP_REGS_SVH
`define DGP_REGS_SVH

// ==========================================================================
// Register offsets
`define DGP_OFS_A_LATCH   16'h0000
`define DGP_OFS_B_LATCH   16'h0001
`define DGP_OFS_A_DIR     16'h0004
`define DGP_OFS_B_DIR     16'h0005
`define DGP_OFS_A_PULLUP  16'h000d

// ==========================================================================
// Reset values and unmapped read value
`define DGP_DIR_RESET     8'h00
`define DGP_PULLUP_RESET  8'h00
`define DGP_UNMAPPED_READ 8'h00

// ==========================================================================
// Converter channel select layout
`define DGP_ADC_CH_W      5
`define DGP_ADC_A_BASE    5'h08
`define DGP_ADC_B_BASE    5'h00

`endif

// ==== hdl/dgp_sync.sv ====
// Two-stage synchroniser for a vector of pin levels
// Assumes inputs are asynchronous to clock_i
`default_nettype none

module dgp_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clock_i,
  input  wire logic             srst_i,
  // Data
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  if (WIDTH < 1) begin : g_bad_width
    $error("dgp_sync: WIDTH must be positive");
  end

  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule // dgp_sync

`default_nettype wire
